// ===== mrd_consts.svh
`ifndef MRD_CONSTS_SVH
`define MRD_CONSTS_SVH
// Region bounds
`define MRD_ROM_HI      32'h0000_FFFF
`define MRD_SRAM_LO     32'h0800_0000
`define MRD_SRAM_HI     32'h0801_FFFF
`define MRD_AFL_LO      32'h1000_0000
`define MRD_AFL_HI      32'h1003_FFFF
`define MRD_SFL_LO      32'h1600_0000
`define MRD_SFL_HI      32'h1600_7FFF
`define MRD_DATA_LO     32'h2000_0000
`define MRD_DATA_HI     32'h3FFF_FFFF
`define MRD_PER_LO      32'h4000_0000
`define MRD_PER_HI      32'h5FFF_FFFF
`define MRD_SERIAL_MEMORY_INTERFACE_LO     32'h6000_0000
`define MRD_SERIAL_MEMORY_INTERFACE_HI     32'h9FFF_FFFF
`define MRD_EXT_LO      32'hA000_0000
`define MRD_EXT_HI      32'hDFFF_FFFF
`define MRD_PPB_LO      32'hE000_0000
`define MRD_PPB_HI      32'hE00F_FFFF
`define MRD_SYS_LO      32'hE010_A000
// Address fields
`define MRD_BLK_MSB     16
`define MRD_BLK_LSB     15
`define MRD_ROW_MSB     17
`define MRD_ROW_LSB     9
`define MRD_SECTOR_BIT  17
`define MRD_WSEL_MSB    3
`define MRD_WSEL_LSB    2
// Masters, contexts, rights bits
`define MRD_MST_SECOND  2'h1
`define MRD_CTX_BOOT    3'h0
`define MRD_RGT_RD      0
`define MRD_RGT_WR      1
`define MRD_RGT_EX      2
// Reset values
`define MRD_CTX_RST     24'h00_0000
`define MRD_RIGHTS_RST  24'hFF_FFFF
`define MRD_PWR_RST     4'hF
`define MRD_RET_RST     4'h0
`define MRD_WORD_RST    32'h0000_0000
// Configuration selectors
`define MRD_CFG_CTX     2'h0
`define MRD_CFG_RIGHTS  2'h1
`define MRD_CFG_SRAM    2'h2
// Fuse array
`define MRD_FUSE_BITS   1024
`define MRD_FUSE_SYS    10'h200
`define MRD_FUSE_SECURE 10'h1F0
`define MRD_FUSE_RST    1024'h0
`endif

// ===== mrd_pkg.sv
package mrd_pkg;
`include "mrd_consts.svh"
  typedef enum logic [7:0] {
    MRD_TGT_NONE   = 8'h00,
    MRD_TGT_ROM    = 8'h01,
    MRD_TGT_SRAM   = 8'h02,
    MRD_TGT_AFLASH = 8'h04,
    MRD_TGT_SUPERVISORY_FLASH = 8'h08,
    MRD_TGT_PERIPH = 8'h10,
    MRD_TGT_SERIAL_MEMORY_INTERFACE   = 8'h20,
    MRD_TGT_PPB    = 8'h40,
    MRD_TGT_SYSREG = 8'h80
  } mrd_tgt_t;
  typedef enum logic [2:0] {
    MRD_ST_IDLE = 3'h1,
    MRD_ST_WAIT = 3'h2,
    MRD_ST_RESP = 3'h4
  } mrd_state_t;
  typedef enum logic [2:0] {
    MRD_ERR_NONE     = 3'h0,
    MRD_ERR_UNMAPPED = 3'h1,
    MRD_ERR_NOEXEC   = 3'h2,
    MRD_ERR_RIGHTS   = 3'h3,
    MRD_ERR_POWER    = 3'h4,
    MRD_ERR_LOCKED   = 3'h5,
    MRD_ERR_ROMPRIV  = 3'h6,
    MRD_ERR_READONLY = 3'h7
  } mrd_err_t;
  typedef struct packed {
    mrd_state_t       state;
    logic             ulp_meta;
    logic             ultra_low_power_mode;
    logic [7:0][2:0]  ctx_map;
    logic [7:0][2:0]  rights;
    logic [3:0]       sram_pwr;
    logic [3:0]       sram_ret;
    mrd_tgt_t         tgt;
    logic [31:0]      addr;
    logic             write;
    logic [31:0]      wdata;
    logic [1:0]       master;
    logic [2:0]       ctx;
    mrd_err_t         cause;
    logic [31:0]      rdata;
    logic [31:0]      err_addr;
    logic             fuse_err;
  } mrd_top_t;
  typedef struct packed {
    logic [`MRD_FUSE_BITS-1:0] fuse;
    logic                      rd_bit;
  } mrd_fuse_t;
endpackage

// ===== mrd_fuse.sv
`timescale 1ns/100ps
`include "mrd_consts.svh"
module mrd_fuse (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Programming
  input  wire logic       prog,
  input  wire logic [9:0] prog_index,
  // Read and lifecycle
  input  wire logic [9:0] rd_index,
  output logic            rd_bit,
  output logic            secure
);
  mrd_pkg::mrd_fuse_t s;
  mrd_pkg::mrd_fuse_t n;

  always_comb begin
    n = s;
    // Only ever sets a bit; only reset clears them
    if (prog) begin
      n.fuse[prog_index] = 1'b1;
    end
    n.rd_bit = s.fuse[rd_index];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{fuse: `MRD_FUSE_RST, rd_bit: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign rd_bit = s.rd_bit;
  assign secure = s.fuse[`MRD_FUSE_SECURE];
endmodule

// ===== mrd_decoder.sv
// Contract
// - Low 64 KB goes to boot ROM.
// - SRAM window up to 128 KB.
// - Application flash window up to 256 KB.
// - Supervisory flash window of 32 KB.
// - Peripheral space, never instruction fetch.
// - Serial memory space, fetch allowed.
// - Architectural data region has no memory.
// - External device region has no target.
// - Private core space goes to issuing core.
// - Top space goes to system registers.
// - Same fixed map for every master.
// - Flash reads fetch 128-bit lines.
// - Flash programs 512-byte rows, 128 KB sectors.
// - No flash writes in ultra low power.
// - SRAM power and retention per 32 KB.
// - ROM fetch only secondary core, context 0.
// - Eight contexts per master and privilege.
// - 1024 fuses, lower 512 system owned.
// - Fuses start 0, set once, never clear; here RESET_N clears all of them.
// - Secure stage locks supervisory flash writes.
`timescale 1ns/100ps
`include "mrd_consts.svh"
module mrd_decoder (
  // Clock and reset
  input  wire logic         MCLK,
  input  wire logic         RESET_N,
  // Master request
  input  wire logic         REQ_VALID,
  input  wire logic [31:0]  REQ_ADDR,
  input  wire logic         REQ_WRITE,
  input  wire logic         REQ_FETCH,
  input  wire logic [31:0]  REQ_WDATA,
  input  wire logic [1:0]   REQ_MASTER,
  input  wire logic         REQ_PRIV,
  // Master response
  output logic              RESP_VALID,
  output logic              RESP_ERROR,
  output logic [2:0]        RESP_CAUSE,
  output logic [31:0]       RESP_RDATA,
  output logic [31:0]       ERR_ADDR,
  // Target side
  output logic              TGT_VALID,
  output logic [7:0]        TGT_SEL,
  output logic [31:0]       TGT_ADDR,
  output logic              TGT_WRITE,
  output logic [31:0]       TGT_WDATA,
  output logic [1:0]        TGT_MASTER,
  output logic [2:0]        TGT_CTX,
  output logic [8:0]        TGT_ROW,
  output logic              TGT_SECTOR,
  input  wire logic         TGT_READY,
  input  wire logic [31:0]  TGT_RDATA,
  input  wire logic [127:0] FLASH_RDATA,
  // Power
  input  wire logic         ULTRA_LOW_POWER_MODE,
  output logic [3:0]        SRAM_PWR_EN,
  output logic [3:0]        SRAM_RETAIN,
  // Boot configuration
  input  wire logic         CFG_VALID,
  input  wire logic [1:0]   CFG_SEL,
  input  wire logic [2:0]   CFG_INDEX,
  input  wire logic [2:0]   CFG_DATA,
  // Fuse array
  input  wire logic         FUSE_PROG_VALID,
  input  wire logic [9:0]   FUSE_PROG_INDEX,
  input  wire logic [1:0]   FUSE_MASTER,
  input  wire logic         FUSE_PRIV,
  output logic              FUSE_PROG_ERR,
  input  wire logic [9:0]   FUSE_RD_INDEX,
  output logic              FUSE_RD_BIT,
  output logic              SECURE_STAGE
);
  mrd_pkg::mrd_top_t s;
  mrd_pkg::mrd_top_t n;

  mrd_pkg::mrd_tgt_t tgt_c;
  mrd_pkg::mrd_err_t cause_c;
  logic [2:0]        ctx_c;
  logic [2:0]        rgt_c;
  logic [2:0]        fctx_c;
  logic              fuse_ok_c;
  logic              secure;
  logic              is_flash_c;
  logic              data_c;
  logic              write_c;
  logic [3:0][31:0]  line_c;

  // Address map, independent of the requesting master
  function automatic mrd_pkg::mrd_tgt_t decode(input logic [31:0] a);
    mrd_pkg::mrd_tgt_t t;
    t = mrd_pkg::MRD_TGT_NONE;
    if (a <= `MRD_ROM_HI) begin
      t = mrd_pkg::MRD_TGT_ROM;
    end else if (a >= `MRD_SRAM_LO && a <= `MRD_SRAM_HI) begin
      t = mrd_pkg::MRD_TGT_SRAM;
    end else if (a >= `MRD_AFL_LO && a <= `MRD_AFL_HI) begin
      t = mrd_pkg::MRD_TGT_AFLASH;
    end else if (a >= `MRD_SFL_LO && a <= `MRD_SFL_HI) begin
      t = mrd_pkg::MRD_TGT_SUPERVISORY_FLASH;
    end else if (a >= `MRD_DATA_LO && a <= `MRD_DATA_HI) begin
      t = mrd_pkg::MRD_TGT_NONE;
    end else if (a >= `MRD_PER_LO && a <= `MRD_PER_HI) begin
      t = mrd_pkg::MRD_TGT_PERIPH;
    end else if (a >= `MRD_SERIAL_MEMORY_INTERFACE_LO && a <= `MRD_SERIAL_MEMORY_INTERFACE_HI) begin
      t = mrd_pkg::MRD_TGT_SERIAL_MEMORY_INTERFACE;
    end else if (a >= `MRD_EXT_LO && a <= `MRD_EXT_HI) begin
      t = mrd_pkg::MRD_TGT_NONE;
    end else if (a >= `MRD_PPB_LO && a <= `MRD_PPB_HI) begin
      t = mrd_pkg::MRD_TGT_PPB;
    end else if (a >= `MRD_SYS_LO) begin
      t = mrd_pkg::MRD_TGT_SYSREG;
    end
    return t;
  endfunction

  always_comb begin
    n = s;
    tgt_c = decode(REQ_ADDR);
    ctx_c = s.ctx_map[{REQ_MASTER, REQ_PRIV}];
    rgt_c = s.rights[ctx_c];
    is_flash_c = (tgt_c == mrd_pkg::MRD_TGT_AFLASH) ||
                 (tgt_c == mrd_pkg::MRD_TGT_SUPERVISORY_FLASH);
    data_c = !REQ_FETCH && !REQ_WRITE;
    // A fetch is a read even with the write line up
    write_c = REQ_WRITE && !REQ_FETCH;
    line_c = FLASH_RDATA;

    // Ultra low power pin synchroniser
    n.ulp_meta = ULTRA_LOW_POWER_MODE;
    n.ultra_low_power_mode = s.ulp_meta;

    // Access checks, first failing one names the cause
    cause_c = mrd_pkg::MRD_ERR_NONE;
    if (tgt_c == mrd_pkg::MRD_TGT_NONE) begin
      cause_c = mrd_pkg::MRD_ERR_UNMAPPED;
    end else if (REQ_FETCH && (tgt_c == mrd_pkg::MRD_TGT_PERIPH ||
                 tgt_c == mrd_pkg::MRD_TGT_PPB ||
                 tgt_c == mrd_pkg::MRD_TGT_SYSREG)) begin
      cause_c = mrd_pkg::MRD_ERR_NOEXEC;
    end else if (REQ_FETCH && tgt_c == mrd_pkg::MRD_TGT_ROM &&
                 !(REQ_MASTER == `MRD_MST_SECOND && ctx_c == `MRD_CTX_BOOT)) begin
      cause_c = mrd_pkg::MRD_ERR_ROMPRIV;
    end else if (write_c && tgt_c == mrd_pkg::MRD_TGT_ROM) begin
      cause_c = mrd_pkg::MRD_ERR_READONLY;
    end else if ((REQ_FETCH && !rgt_c[`MRD_RGT_EX]) ||
                 (write_c && !rgt_c[`MRD_RGT_WR]) ||
                 (data_c && !rgt_c[`MRD_RGT_RD])) begin
      cause_c = mrd_pkg::MRD_ERR_RIGHTS;
    end else if (tgt_c == mrd_pkg::MRD_TGT_SRAM &&
                 !s.sram_pwr[REQ_ADDR[`MRD_BLK_MSB:`MRD_BLK_LSB]]) begin
      cause_c = mrd_pkg::MRD_ERR_POWER;
    end else if (write_c && is_flash_c && s.ultra_low_power_mode) begin
      cause_c = mrd_pkg::MRD_ERR_POWER;
    end else if (write_c && tgt_c == mrd_pkg::MRD_TGT_SUPERVISORY_FLASH && secure) begin
      cause_c = mrd_pkg::MRD_ERR_LOCKED;
    end

    // Access sequencer
    unique case (s.state)
      mrd_pkg::MRD_ST_IDLE: begin
        if (REQ_VALID) begin
          // Request fields are captured once and held in registers, so the master need not hold them
          n.addr = REQ_ADDR;
          n.write = write_c;
          n.wdata = REQ_WDATA;
          n.master = REQ_MASTER;
          n.ctx = ctx_c;
          n.tgt = tgt_c;
          n.cause = cause_c;
          n.rdata = `MRD_WORD_RST;
          if (cause_c != mrd_pkg::MRD_ERR_NONE) begin
            n.err_addr = REQ_ADDR;
            n.state = mrd_pkg::MRD_ST_RESP;
          end else begin
            n.state = mrd_pkg::MRD_ST_WAIT;
          end
        end
      end
      mrd_pkg::MRD_ST_WAIT: begin
        if (TGT_READY) begin
          if (!s.write && (s.tgt == mrd_pkg::MRD_TGT_AFLASH ||
                           s.tgt == mrd_pkg::MRD_TGT_SUPERVISORY_FLASH)) begin
            // Word picked out of the wide flash line
            n.rdata = line_c[s.addr[`MRD_WSEL_MSB:`MRD_WSEL_LSB]];
          end else if (!s.write) begin
            n.rdata = TGT_RDATA;
          end
          n.state = mrd_pkg::MRD_ST_RESP;
        end
      end
      mrd_pkg::MRD_ST_RESP: begin
        n.state = mrd_pkg::MRD_ST_IDLE;
      end
      default: begin
        n.state = mrd_pkg::MRD_ST_IDLE;
      end
    endcase

    // Boot time configuration of contexts, rights and SRAM power
    if (CFG_VALID) begin
      unique case (CFG_SEL)
        `MRD_CFG_CTX: begin
          n.ctx_map[CFG_INDEX] = CFG_DATA;
        end
        `MRD_CFG_RIGHTS: begin
          n.rights[CFG_INDEX] = CFG_DATA;
        end
        `MRD_CFG_SRAM: begin
          n.sram_pwr[CFG_INDEX[1:0]] = CFG_DATA[0];
          n.sram_ret[CFG_INDEX[1:0]] = CFG_DATA[1];
        end
        default: begin
        end
      endcase
    end

    // System half of the fuses only from the boot context
    fctx_c = s.ctx_map[{FUSE_MASTER, FUSE_PRIV}];
    fuse_ok_c = FUSE_PROG_VALID &&
                (FUSE_PROG_INDEX >= `MRD_FUSE_SYS || fctx_c == `MRD_CTX_BOOT);
    n.fuse_err = FUSE_PROG_VALID && !fuse_ok_c;
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '{
        state:    mrd_pkg::MRD_ST_IDLE,
        ulp_meta: 1'b0,
        ultra_low_power_mode:      1'b0,
        ctx_map:  `MRD_CTX_RST,
        rights:   `MRD_RIGHTS_RST,
        sram_pwr: `MRD_PWR_RST,
        sram_ret: `MRD_RET_RST,
        tgt:      mrd_pkg::MRD_TGT_NONE,
        addr:     `MRD_WORD_RST,
        write:    1'b0,
        wdata:    `MRD_WORD_RST,
        master:   2'h0,
        ctx:      `MRD_CTX_BOOT,
        cause:    mrd_pkg::MRD_ERR_NONE,
        rdata:    `MRD_WORD_RST,
        err_addr: `MRD_WORD_RST,
        fuse_err: 1'b0
      };
    end else begin
      s <= n;
    end
  end

  mrd_fuse u_fuse (
    .clk        (MCLK),
    .rst_n      (RESET_N),
    .prog       (fuse_ok_c),
    .prog_index (FUSE_PROG_INDEX),
    .rd_index   (FUSE_RD_INDEX),
    .rd_bit     (FUSE_RD_BIT),
    .secure     (secure)
  );

  // Response side
  assign RESP_VALID = (s.state == mrd_pkg::MRD_ST_RESP);
  assign RESP_ERROR = (s.cause != mrd_pkg::MRD_ERR_NONE);
  assign RESP_CAUSE = s.cause;
  assign RESP_RDATA = s.rdata;
  assign ERR_ADDR   = s.err_addr;

  // Target side
  assign TGT_VALID  = (s.state == mrd_pkg::MRD_ST_WAIT);
  assign TGT_SEL    = s.tgt;
  assign TGT_ADDR   = s.addr;
  assign TGT_WRITE  = s.write;
  assign TGT_WDATA  = s.wdata;
  assign TGT_MASTER = s.master;
  assign TGT_CTX    = s.ctx;
  assign TGT_ROW    = s.addr[`MRD_ROW_MSB:`MRD_ROW_LSB];
  assign TGT_SECTOR = s.addr[`MRD_SECTOR_BIT];

  // Power, fuse and lifecycle status
  assign SRAM_PWR_EN   = s.sram_pwr;
  assign SRAM_RETAIN   = s.sram_ret;
  assign FUSE_PROG_ERR = s.fuse_err;
  assign SECURE_STAGE  = secure;
endmodule

// ===== mrd_decoder_asserts.sv
`timescale 1ns/100ps
module mrd_decoder_asserts (
  // Clock and reset
  input logic        MCLK,
  input logic        RESET_N,
  // Master side
  input logic        REQ_VALID,
  input logic [31:0] REQ_ADDR,
  input logic        REQ_FETCH,
  input logic        RESP_VALID,
  input logic        RESP_ERROR,
  input logic [2:0]  RESP_CAUSE,
  // Target side
  input logic        TGT_VALID,
  input logic [7:0]  TGT_SEL,
  input logic [31:0] TGT_ADDR,
  input logic        TGT_WRITE,
  input logic [8:0]  TGT_ROW,
  input logic        TGT_SECTOR,
  input logic        TGT_READY,
  input logic        SECURE_STAGE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  wire idle = REQ_VALID && !TGT_VALID && !RESP_VALID;
  rom_route_a: assert property (
    TGT_VALID && TGT_ADDR <= 32'h0000_FFFF |-> TGT_SEL == 8'h01) else $error("ROM route");
  sram_route_a: assert property (
    TGT_VALID && TGT_ADDR inside {[32'h0800_0000:32'h0801_FFFF]} |-> TGT_SEL == 8'h02)
    else $error("SRAM route");
  flash_route_a: assert property (
    TGT_VALID && TGT_ADDR inside {[32'h1000_0000:32'h1003_FFFF]} |-> TGT_SEL == 8'h04)
    else $error("Flash route");
  serial_route_a: assert property (
    TGT_VALID && TGT_ADDR inside {[32'h6000_0000:32'h9FFF_FFFF]} |-> TGT_SEL == 8'h20)
    else $error("Serial route");
  hole_error_a: assert property (
    idle && REQ_ADDR inside {[32'h2000_0000:32'h3FFF_FFFF], [32'hA000_0000:32'hDFFF_FFFF]}
    |=> RESP_VALID && RESP_ERROR && RESP_CAUSE == 3'h1) else $error("Hole not refused");
  periph_noexec_a: assert property (
    idle && REQ_FETCH && REQ_ADDR[31:29] == 3'h2 |=> RESP_VALID && RESP_ERROR
    && RESP_CAUSE == 3'h2) else $error("Peripheral fetch");
  done_resp_a: assert property (
    TGT_VALID && TGT_READY |=> RESP_VALID && !RESP_ERROR && !TGT_VALID) else $error("No done");
  row_sector_a: assert property (
    TGT_VALID |-> TGT_ROW == TGT_ADDR[17:9] && TGT_SECTOR == TGT_ADDR[17]) else $error("Row");
  secure_lock_a: assert property (
    TGT_VALID && TGT_WRITE && TGT_SEL == 8'h08 |-> !SECURE_STAGE) else $error("Locked write");
endmodule

// ===== mrd_tgt_model.sv
`timescale 1ns/100ps
module mrd_tgt_model (
  input  logic         clk,
  input  logic         rst_n,
  input  logic         valid,
  input  logic [31:0]  addr,
  output logic         ready,
  output logic [31:0]  rdata,
  output logic [127:0] flash
);
  logic [1:0]  wait_cnt;
  logic        slow;
  logic [31:0] junk;
  // Alternate prompt and slow answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      junk <= 32'h0000_0000;
    end else begin
      junk <= junk + 32'h1357_9BDF;
      if (ready) begin
        wait_cnt <= 2'h0;
        slow <= !slow;
      end else if (valid) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
  assign ready = valid && (!slow || wait_cnt == 2'h3);
  assign rdata = valid ? ~addr : junk;
  // Word i of the line is addr xor i
  assign flash = valid ? {4{addr}} ^ {30'h0, 2'h3, 30'h0, 2'h2, 30'h0, 2'h1, 32'h0} : {4{junk}};
endmodule

// ===== test_mrd_decoder.sv
`timescale 1ns/100ps
bind mrd_decoder mrd_decoder_asserts u_chk (.MCLK, .RESET_N, .REQ_VALID, .REQ_ADDR,
  .REQ_FETCH, .RESP_VALID, .RESP_ERROR, .RESP_CAUSE, .TGT_VALID, .TGT_SEL, .TGT_ADDR,
  .TGT_WRITE, .TGT_ROW, .TGT_SECTOR, .TGT_READY, .SECURE_STAGE);
module test_mrd_decoder;
  logic MCLK = 1'b0, RESET_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_FETCH = 1'b0;
  logic [31:0] REQ_ADDR = 32'h0, REQ_WDATA = 32'h0, TGT_RDATA, RESP_RDATA, ERR_ADDR, TGT_ADDR;
  logic [31:0] TGT_WDATA;
  logic [1:0] REQ_MASTER = 2'h0, CFG_SEL = 2'h0, FUSE_MASTER = 2'h0, TGT_MASTER;
  logic REQ_PRIV = 1'b0, ULTRA_LOW_POWER_MODE = 1'b0, CFG_VALID = 1'b0, FUSE_PRIV = 1'b0;
  logic [2:0] CFG_INDEX = 3'h0, CFG_DATA = 3'h0, RESP_CAUSE, TGT_CTX;
  logic FUSE_PROG_VALID = 1'b0, RESP_VALID, RESP_ERROR, TGT_VALID, TGT_WRITE, TGT_SECTOR;
  logic [9:0] FUSE_PROG_INDEX = 10'h0, FUSE_RD_INDEX = 10'h0;
  logic TGT_READY, FUSE_PROG_ERR, FUSE_RD_BIT, SECURE_STAGE;
  logic [7:0] TGT_SEL;
  logic [8:0] TGT_ROW;
  logic [127:0] FLASH_RDATA;
  logic [3:0] SRAM_PWR_EN, SRAM_RETAIN;
  int fails = 0;
  int comparisons = 0;
  always #10 MCLK = ~MCLK;
  mrd_decoder dut (.*);
  mrd_tgt_model u_tgt (.clk(MCLK), .rst_n(RESET_N), .valid(TGT_VALID), .addr(TGT_ADDR),
    .ready(TGT_READY), .rdata(TGT_RDATA), .flash(FLASH_RDATA));
  task automatic conclude;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  // One access; sel 0 expects an error, cause 0 accepts any cause
  task automatic acc(input logic [31:0] a, input logic w, f, input logic [1:0] m,
      input logic [7:0] sel, input logic [2:0] cause);
    int n;
    logic [7:0] seen;
    logic tw, ts;
    logic [31:0] ta, twd;
    logic [1:0] tm;
    logic [2:0] tc;
    logic [8:0] tr;
    seen = 8'h00;
    {tw, ts, ta, twd, tm, tc, tr} = '0;
    @(negedge MCLK);
    {REQ_VALID, REQ_ADDR, REQ_WRITE, REQ_FETCH, REQ_MASTER, REQ_WDATA} = {1'b1, a, w, f, m, ~a};
    for (n = 0; n < 20 && RESP_VALID !== 1'b1; n++) begin
      @(negedge MCLK);
      if (TGT_VALID === 1'b1) begin
        seen = TGT_SEL;
        {tw, ts, ta, twd, tm, tc, tr} = {TGT_WRITE, TGT_SECTOR, TGT_ADDR, TGT_WDATA,
                                         TGT_MASTER, TGT_CTX, TGT_ROW};
      end
    end
    REQ_VALID = 1'b0;
    if (n == 20) begin
      fails++;
      conclude();
    end
    chk(seen, sel, "target");
    if (sel != 8'h00) begin
      chk(ta, a, "tgt addr");
      chk(tw, w && !f, "tgt write");
      chk(tm, m, "tgt master");
      chk(tc, 3'h0, "tgt ctx");
      chk(tr, a[17:9], "tgt row");
      chk(ts, a[17], "tgt sector");
      if (w && !f) chk(twd, ~a, "tgt wdata");
    end
    chk(RESP_ERROR, sel == 8'h00, "error");
    if (sel == 8'h00 && cause != 3'h0) chk(RESP_CAUSE, cause, "cause");
    if (sel == 8'h00) chk(ERR_ADDR, a, "err addr");
    else if (!w && (sel == 8'h04 || sel == 8'h08)) chk(RESP_RDATA, a ^ {30'h0, a[3:2]}, "line");
    else if (!w) chk(RESP_RDATA, ~a, "rdata");
  endtask
  task automatic cfg(input logic [1:0] s, input logic [2:0] i, d);
    @(negedge MCLK);
    {CFG_VALID, CFG_SEL, CFG_INDEX, CFG_DATA} = {1'b1, s, i, d};
    @(negedge MCLK);
    CFG_VALID = 1'b0;
  endtask
  task automatic prog(input logic [9:0] i);
    @(negedge MCLK);
    {FUSE_PROG_VALID, FUSE_PROG_INDEX} = {1'b1, i};
    @(negedge MCLK);
    FUSE_PROG_VALID = 1'b0;
  endtask
  task automatic t_map;
    acc(32'h0000_FFF0, 0, 0, 0, 8'h01, 0);
    acc(32'h0001_0000, 0, 0, 0, 8'h00, 1);
    acc(32'h0801_FFFC, 0, 0, 2, 8'h02, 0);
    acc(32'h0800_0000, 0, 0, 1, 8'h02, 0);
    acc(32'h1003_FFF8, 0, 0, 3, 8'h04, 0);
    acc(32'h1004_0000, 0, 0, 0, 8'h00, 1);
    acc(32'h1600_7FF4, 0, 0, 1, 8'h08, 0);
    acc(32'h1600_8000, 0, 0, 0, 8'h00, 1);
    acc(32'h5FFF_FFFC, 1, 0, 0, 8'h10, 0);
    acc(32'h9FFF_FFF0, 0, 1, 0, 8'h20, 0);
    acc(32'h3FFF_FFFC, 0, 0, 0, 8'h00, 1);
    acc(32'hA000_0000, 0, 0, 3, 8'h00, 1);
    acc(32'hE00F_FFFC, 0, 0, 1, 8'h40, 0);
    acc(32'hE010_9FFC, 0, 0, 0, 8'h00, 1);
    acc(32'hE010_A000, 0, 0, 0, 8'h80, 0);
  endtask
  task automatic t_exec;
    acc(32'h4000_0000, 0, 1, 0, 8'h00, 2);
    acc(32'hE000_0000, 0, 1, 1, 8'h00, 2);
    acc(32'h0000_0100, 0, 1, 0, 8'h00, 6);
    acc(32'h0000_0100, 0, 1, 1, 8'h01, 0);
    cfg(2'h0, 3'h2, 3'h3);
    acc(32'h0000_0100, 0, 1, 1, 8'h00, 6);
    cfg(2'h0, 3'h2, 3'h0);
    acc(32'h0000_0200, 1, 0, 1, 8'h00, 7);
  endtask
  task automatic t_power;
    ULTRA_LOW_POWER_MODE = 1'b1;
    cyc(3);
    acc(32'h1000_0200, 1, 0, 0, 8'h00, 4);
    acc(32'h1000_0214, 0, 0, 0, 8'h04, 0);
    ULTRA_LOW_POWER_MODE = 1'b0;
    cyc(3);
    acc(32'h1002_0400, 1, 0, 0, 8'h04, 0);
    cfg(2'h2, 3'h1, 3'h2);
    chk(SRAM_PWR_EN, 4'hD, "power");
    chk(SRAM_RETAIN, 4'h2, "retain");
    acc(32'h0800_8000, 0, 0, 0, 8'h00, 0);
    acc(32'h0800_7FFC, 0, 0, 0, 8'h02, 0);
    cfg(2'h2, 3'h1, 3'h1);
  endtask
  task automatic t_fuse;
    FUSE_RD_INDEX = 10'h1F0;
    cyc(2);
    chk(FUSE_RD_BIT, 0, "fuse default");
    acc(32'h1600_0000, 1, 0, 0, 8'h08, 0);
    prog(10'h1F0);
    prog(10'h1F0);
    cyc(1);
    chk(SECURE_STAGE, 1, "secure");
    chk(FUSE_RD_BIT, 1, "fuse set");
    acc(32'h1600_0000, 1, 0, 0, 8'h00, 5);
    acc(32'h1600_0000, 0, 0, 0, 8'h08, 0);
    cfg(2'h0, 3'h0, 3'h2);
    prog(10'h005);
    chk(FUSE_PROG_ERR, 1, "system fuse");
    prog(10'h200);
    chk(FUSE_PROG_ERR, 0, "customer fuse");
    FUSE_RD_INDEX = 10'h005;
    cyc(2);
    chk(FUSE_RD_BIT, 0, "refused fuse");
    FUSE_RD_INDEX = 10'h200;
    cyc(2);
    chk(FUSE_RD_BIT, 1, "customer bit");
    cfg(2'h0, 3'h0, 3'h0);
  endtask
  initial begin
    cyc(12);
    RESET_N = 1'b1;
    chk(SRAM_PWR_EN, 4'hF, "power reset");
    chk(SECURE_STAGE, 0, "secure reset");
    t_map();
    t_exec();
    t_power();
    t_fuse();
    conclude();
  end
endmodule
